// File: serial_port_regs.sv
// serial peripheral: register file, status flags and byte shifter
module serial_port_regs #(
    parameter int DIV_HALF = 4
)
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial link
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic sel_n_in,
    // interrupt
    output logic irq
);
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic acc;
    logic wr;
    logic rd;
    logic hit;
    logic [7:0] idx;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign idx = paddr[9:2];
    assign hit = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00 &&
        (idx == serial_pkg::IDX_DATA || idx == serial_pkg::IDX_CTRL ||
         idx == serial_pkg::IDX_CSR || idx == serial_pkg::IDX_IRQ_STAT ||
         idx == serial_pkg::IDX_IRQ_CLR || idx == serial_pkg::IDX_IRQ_EN);
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    logic wr_data;
    logic wr_ctrl;
    logic wr_csr;
    logic rd_data;
    logic acc_csr;
    assign wr_data = wr && hit && idx == serial_pkg::IDX_DATA;
    assign rd_data = rd && hit && idx == serial_pkg::IDX_DATA;
    assign wr_ctrl = wr && hit && idx == serial_pkg::IDX_CTRL;
    assign wr_csr = wr && hit && idx == serial_pkg::IDX_CSR;
    assign acc_csr = acc && hit && idx == serial_pkg::IDX_CSR;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // idle pin levels: select high, clock low, so no false edge after reset
            s1_r <= 4'h8;
            s2_r <= 4'h8;
        end
        else
        begin
            s1_r <= {sel_n_in, sck_in, mosi_in, miso_in};
            s2_r <= s1_r;
        end
    end
    logic pin_sel_n;
    logic pin_sck;
    logic pin_mosi;
    logic pin_miso;
    assign {pin_sel_n, pin_sck, pin_mosi, pin_miso} = s2_r;

    // ----------------------------------------
    // control and status bits
    // ----------------------------------------
    logic [7:0] ctrl_r;
    logic done_r;
    logic write_collision_flag_r;
    logic ovr_r;
    logic mode_fault_flag_r;
    logic out_dis_r;
    logic sel_src_r;
    logic int_sel_r;
    logic done_seen_r;
    logic mode_fault_flag_seen_r;
    logic busy_r;
    logic xfer_end;
    logic master;
    logic sel_n;
    logic fault;
    assign master = ctrl_r[serial_pkg::CR_MASTER];
    assign sel_n = sel_src_r ? int_sel_r : pin_sel_n;
    assign fault = master && !sel_n;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= serial_pkg::CR_RESET;
        else if (fault)
        begin
            if (wr_ctrl)
                ctrl_r <= pwdata[7:0];
            ctrl_r[serial_pkg::CR_PORT_EN] <= 1'b0;
            ctrl_r[serial_pkg::CR_MASTER] <= 1'b0;
        end
        else if (wr_ctrl)
            ctrl_r <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_dis_r <= 1'b0;
            sel_src_r <= 1'b0;
            int_sel_r <= 1'b0;
        end
        else if (wr_csr)
        begin
            out_dis_r <= pwdata[serial_pkg::CS_OUT_DIS];
            sel_src_r <= pwdata[serial_pkg::CS_SEL_SRC];
            int_sel_r <= pwdata[serial_pkg::CS_INT_SEL];
        end
    end

    // mode fault set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_fault_flag_r <= 1'b0;
            mode_fault_flag_seen_r <= 1'b0;
        end
        else
        begin
            if (fault)
                mode_fault_flag_r <= 1'b1;
            else if (mode_fault_flag_seen_r && wr_ctrl)
                mode_fault_flag_r <= 1'b0;
            if (acc_csr && mode_fault_flag_r)
                mode_fault_flag_seen_r <= 1'b1;
            else if (wr_ctrl || !mode_fault_flag_r)
                mode_fault_flag_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_r <= 1'b0;
            done_seen_r <= 1'b0;
            ovr_r <= 1'b0;
        end
        else
        begin
            if (xfer_end)
                done_r <= 1'b1;
            else if (done_seen_r && (wr_data || rd_data))
                done_r <= 1'b0;
            if (acc_csr && done_r)
                done_seen_r <= 1'b1;
            else if (wr_data || rd_data || !done_r)
                done_seen_r <= 1'b0;
            if (xfer_end && done_r)
                ovr_r <= 1'b1;
            else if (rd && hit && idx == serial_pkg::IDX_CSR)
                ovr_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            write_collision_flag_r <= 1'b0;
        else if (wr_data && busy_r)
            write_collision_flag_r <= 1'b1;
        else if (done_seen_r && rd_data)
            write_collision_flag_r <= 1'b0;
    end

    // ----------------------------------------
    // shifter
    // ----------------------------------------
    logic [7:0] shift_r;
    logic [7:0] rx_buf_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] div_r;
    logic tick;
    logic sck_r;
    logic sck_d_r;
    logic lead;
    logic samp;
    logic load;
    logic cpol;
    logic cpha;
    assign cpol = ctrl_r[serial_pkg::CR_CPOL];
    assign cpha = ctrl_r[serial_pkg::CR_CPHA];
    // writes blocked while done is pending
    assign load = wr_data && !busy_r && !(done_r && !done_seen_r)
        && ctrl_r[serial_pkg::CR_PORT_EN];
    assign tick = div_r == 8'(DIV_HALF - 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_r <= 8'h00;
        else if (!busy_r || tick)
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end

    // master makes the clock; slave watches the synchronised pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_r <= 1'b0;
            sck_d_r <= 1'b0;
        end
        else
        begin
            sck_d_r <= master ? sck_r : pin_sck;
            if (!busy_r || !master)
                sck_r <= cpol;
            else if (tick)
                sck_r <= !sck_r;
        end
    end
    logic sck_now;
    assign sck_now = master ? sck_r : pin_sck;
    assign lead = sck_now != sck_d_r && (sck_now ^ cpol);
    // sample on leading edge when cpha 0, trailing when cpha 1
    assign samp = (sck_now != sck_d_r) && ((sck_now ^ cpol) ^ cpha);
    assign xfer_end = samp && bit_cnt_r == 4'd7;
    logic [7:0] rx_next;
    assign rx_next = {shift_r[6:0], master ? pin_miso : pin_mosi};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_r <= 8'h00;
            rx_buf_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            busy_r <= 1'b0;
        end
        else if (load)
        begin
            shift_r <= pwdata[7:0];
            bit_cnt_r <= 4'h0;
            busy_r <= master;
        end
        else if (!master && sel_n)
        begin
            bit_cnt_r <= 4'h0;
            busy_r <= 1'b0;
        end
        else if (samp)
        begin
            shift_r <= rx_next;
            bit_cnt_r <= bit_cnt_r + 4'h1;
            busy_r <= bit_cnt_r != 4'd7;
            if (bit_cnt_r == 4'd7)
            begin
                rx_buf_r <= rx_next;
                bit_cnt_r <= 4'h0;
            end
        end
        else if (lead && !master)
            busy_r <= 1'b1;
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    logic drive;
    assign drive = ctrl_r[serial_pkg::CR_PORT_EN] && !out_dis_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mosi_out <= 1'b0;
            miso_out <= 1'b0;
        end
        else
        begin
            mosi_out <= shift_r[7];
            miso_out <= shift_r[7];
        end
    end
    assign mosi_oe = drive && master;
    assign miso_oe = drive && !master && !sel_n;
    assign sck_out = sck_r;
    assign sck_oe = ctrl_r[serial_pkg::CR_PORT_EN] && master;

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    logic [3:0] ist_r;
    logic [3:0] ien_r;
    logic [3:0] ev;
    assign ev = {wr_data && busy_r, fault, xfer_end && done_r, xfer_end};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ist_r <= 4'h0;
            ien_r <= 4'h0;
        end
        else
        begin
            ist_r <= (ist_r & ~((wr && hit && idx == serial_pkg::IDX_IRQ_CLR) ?
                pwdata[3:0] : 4'h0)) | ev;
            if (wr && hit && idx == serial_pkg::IDX_IRQ_EN)
                ien_r <= pwdata[3:0];
        end
    end
    assign irq = ctrl_r[serial_pkg::CR_IRQ_EN] &&
        ((done_r || ovr_r || mode_fault_flag_r) || |(ist_r & ien_r));

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd && hit)
        begin
            unique case (idx)
                serial_pkg::IDX_DATA: prdata[7:0] = rx_buf_r;
                serial_pkg::IDX_CTRL: prdata[7:0] = ctrl_r;
                serial_pkg::IDX_CSR: prdata[7:0] = {done_r, write_collision_flag_r, ovr_r, mode_fault_flag_r,
                    1'b0, out_dis_r, sel_src_r, int_sel_r};
                serial_pkg::IDX_IRQ_STAT: prdata[3:0] = ist_r;
                serial_pkg::IDX_IRQ_EN: prdata[3:0] = ien_r;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_FAULT_SETS: assert property (@(posedge pclk) disable iff (!presetn)
        fault |=> mode_fault_flag_r) else $error("mode fault not set");
    AST_FAULT_DROPS: assert property (@(posedge pclk) disable iff (!presetn)
        fault |=> !ctrl_r[serial_pkg::CR_MASTER] && !ctrl_r[serial_pkg::CR_PORT_EN])
        else $error("fault left master on");
    AST_IRQ_MODE_FAULT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        mode_fault_flag_r && ctrl_r[serial_pkg::CR_IRQ_EN] |-> irq) else $error("no irq on fault");
    AST_MODE_FAULT_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        mode_fault_flag_r && !wr_ctrl |=> mode_fault_flag_r) else $error("mode fault lost");
    AST_DIS_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        out_dis_r |-> !mosi_oe && !miso_oe) else $error("output not released");
    AST_DONE_SET: assert property (@(posedge pclk) disable iff (!presetn)
        xfer_end |=> done_r && rx_buf_r == $past(rx_next)) else $error("done not set");
    AST_OVR: assert property (@(posedge pclk) disable iff (!presetn)
        xfer_end && done_r |=> ovr_r) else $error("overrun missed");
    AST_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        wr_data && done_r && !done_seen_r && !samp |=> $stable(shift_r))
        else $error("write not blocked");
    // two-step clears: status access arms, then the second access clears
    sequence mode_fault_flag_armed_s;
        mode_fault_flag_seen_r && wr_ctrl && !fault;
    endsequence
    sequence done_armed_s;
        done_seen_r && (wr_data || rd_data) && !xfer_end;
    endsequence
    AST_MODE_FAULT_FLAG_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        mode_fault_flag_armed_s |=> !mode_fault_flag_r) else $error("mode fault not cleared");
    AST_DONE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        done_armed_s |=> !done_r) else $error("done not cleared");
    AST_WRITE_COLLISION_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        wr_data && busy_r |=> write_collision_flag_r) else $error("collision missed");
endmodule : serial_port_regs

// File: serial_pkg.sv
// package: register map, fields and reset values for the serial port block
package serial_pkg;
    // ----------------------------------------
    // register indices (printed offsets), byte address = 4 * index
    // ----------------------------------------
    localparam logic [7:0] IDX_DATA = 8'h31;
    localparam logic [7:0] IDX_CTRL = 8'h32;
    localparam logic [7:0] IDX_CSR = 8'h33;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h34;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h35;
    localparam logic [7:0] IDX_IRQ_EN = 8'h36;
    localparam int ADDR_W = 12;
    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int CR_IRQ_EN = 7;
    localparam int CR_PORT_EN = 6;
    localparam int CR_DIV_EN = 5;
    localparam int CR_MASTER = 4;
    localparam int CR_CPOL = 3;
    localparam int CR_CPHA = 2;
    localparam int CR_RATE_HI = 1;
    localparam int CR_RATE_LO = 0;
    localparam logic [7:0] CR_RESET = 8'h00;
    // ----------------------------------------
    // control/status register fields
    // ----------------------------------------
    localparam int CS_DONE = 7;
    localparam int CS_WRITE_COLLISION_FLAG = 6;
    localparam int CS_OVR = 5;
    localparam int CS_MODE_FAULT_FLAG = 4;
    localparam int CS_OUT_DIS = 2;
    localparam int CS_SEL_SRC = 1;
    localparam int CS_INT_SEL = 0;
    localparam logic [7:0] CS_RESET = 8'h00;
    // interrupt status bits: 0 done, 1 overrun, 2 mode fault, 3 collision
    localparam int NUM_EV = 4;
    localparam int BITS_PER_BYTE = 8;
endpackage : serial_pkg

// File: spi_far_end.sv
// far-end model: serial slave, mode 0, msb first
module spi_far_end
(
    // link
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // bench side
    input wire logic load,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh_r;
    // capture on rising clock
    always @(posedge sck)
    begin
        rx_byte <= {rx_byte[6:0], mosi};
    end
    // trailing bits toggle so a late sample never sees a held value
    always @(negedge sck or posedge load)
    begin
        if (load)
            sh_r <= tx_byte;
        else
            sh_r <= {sh_r[6:0], ~sh_r[0]};
    end
    assign miso = sh_r[7];
endmodule : spi_far_end

// File: tb_top.sv
// testbench: register, link and interrupt scenarios of the serial port
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, sel_n_in, ld, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe;
    logic miso_out, miso_oe, irq, sck, miso, mosi;
    logic [7:0] ftx, frx;
    logic tb_sck, tb_mosi;
    int n_fail, num_checks;
    // bench plays master on the link when the block lets go of it
    assign sck = sck_oe ? sck_out : tb_sck;
    assign mosi = mosi_oe ? mosi_out : tb_mosi;
    serial_port_regs #(.DIV_HALF(4)) u_serial_port_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sck_in(sck), .sck_out(sck_out),
        .sck_oe(sck_oe), .mosi_in(mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso), .miso_out(miso_out), .miso_oe(miso_oe),
        .sel_n_in(sel_n_in), .irq(irq));
    spi_far_end u_spi_far_end (.sck(sck), .mosi(mosi), .miso(miso), .load(ld),
        .tx_byte(ftx), .rx_byte(frx));
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_of_test();
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 50)
        begin
            chk(0, 1, "bus hang");
            end_of_test();
        end
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string msg);
        apb(1'b0, idx, 32'h0000_0000);
        chk(rd, exp, msg);
    endtask : rdc
    task automatic load_far(input logic [7:0] b);
        @(posedge pclk);
        ftx <= b;
        ld <= 1'b1;
        @(posedge pclk);
        ld <= 1'b0;
    endtask : load_far
    // polls the sticky event bit, leaving the status register untouched
    task automatic wait_done();
        int i;
        for (i = 0; i < 300; i++)
        begin
            apb(1'b0, serial_pkg::IDX_IRQ_STAT, 32'h0000_0000);
            if (rd[0] === 1'b1)
                break;
        end
        if (i == 300)
        begin
            chk(0, 1, "no completion");
            end_of_test();
        end
    endtask : wait_done
    task automatic pin_sel(input logic v);
        @(posedge pclk);
        sel_n_in <= v;
        repeat (8) @(posedge pclk);
    endtask : pin_sel
    // mode 0 master byte, msb first, 64 ns link clock
    task automatic send_slave(input logic [7:0] b);
        int k;
        for (k = 7; k >= 0; k--)
        begin
            tb_mosi <= b[k];
            repeat (4) @(posedge pclk);
            tb_sck <= 1'b1;
            repeat (4) @(posedge pclk);
            tb_sck <= 1'b0;
        end
        repeat (8) @(posedge pclk);
    endtask : send_slave
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rdc(serial_pkg::IDX_CTRL, 32'h0000_0000, "ctrl reset");
        rdc(serial_pkg::IDX_CSR, 32'h0000_0000, "csr reset");
        wr(serial_pkg::IDX_CSR, 32'h0000_000c);
        rdc(serial_pkg::IDX_CSR, 32'h0000_0004, "reserved bit");
        wr(serial_pkg::IDX_CSR, 32'h0000_0000);
        apb(1'b0, 8'h3f, 32'h0000_0000);
        chk(err, 1, "unmapped");
    endtask : t_regs
    task automatic t_xfer();
        wr(serial_pkg::IDX_CTRL, 32'h0000_0050);
        wr(serial_pkg::IDX_IRQ_CLR, 32'h0000_000f);
        load_far(8'h3c);
        wr(serial_pkg::IDX_DATA, 32'h0000_00a5);
        wr(serial_pkg::IDX_DATA, 32'h0000_00ff);
        wait_done();
        rdc(serial_pkg::IDX_CSR, 32'h0000_00c0, "done, collision");
        chk(32'(frx), 32'h0000_00a5, "byte out");
        rdc(serial_pkg::IDX_DATA, 32'h0000_003c, "rx buffer");
        rdc(serial_pkg::IDX_CSR, 32'h0000_0000, "flags clear");
    endtask : t_xfer
    task automatic t_inhibit();
        wr(serial_pkg::IDX_IRQ_CLR, 32'h0000_000f);
        load_far(8'hc3);
        wr(serial_pkg::IDX_DATA, 32'h0000_0069);
        wait_done();
        wr(serial_pkg::IDX_DATA, 32'h0000_0011);
        repeat (150) @(posedge pclk);
        chk(32'(frx), 32'h0000_0069, "inhibited");
        rdc(serial_pkg::IDX_CSR, 32'h0000_0080, "done held");
        wr(serial_pkg::IDX_IRQ_CLR, 32'h0000_000f);
        load_far(8'h96);
        wr(serial_pkg::IDX_DATA, 32'h0000_005a);
        rdc(serial_pkg::IDX_CSR, 32'h0000_0000, "done cleared");
        wait_done();
        chk(32'(frx), 32'h0000_005a, "second byte");
        rdc(serial_pkg::IDX_CSR, 32'h0000_0080, "done again");
        rdc(serial_pkg::IDX_DATA, 32'h0000_0096, "rx buffer");
    endtask : t_inhibit
    task automatic t_oe();
        @(negedge pclk);
        chk(mosi_oe, 1, "oe on");
        wr(serial_pkg::IDX_CSR, 32'h0000_0004);
        @(negedge pclk);
        chk(mosi_oe, 0, "oe disabled");
        wr(serial_pkg::IDX_CSR, 32'h0000_0000);
        wr(serial_pkg::IDX_CTRL, 32'h0000_0010);
        @(negedge pclk);
        chk(mosi_oe, 0, "oe no enable");
    endtask : t_oe
    task automatic t_fault();
        wr(serial_pkg::IDX_IRQ_CLR, 32'h0000_000f);
        wr(serial_pkg::IDX_IRQ_EN, 32'h0000_0004);
        wr(serial_pkg::IDX_CTRL, 32'h0000_00d0);
        pin_sel(1'b0);
        chk(irq, 1, "fault irq");
        pin_sel(1'b1);
        rdc(serial_pkg::IDX_CTRL, 32'h0000_0080, "bits dropped");
        rdc(serial_pkg::IDX_CSR, 32'h0000_0010, "mode fault");
        wr(serial_pkg::IDX_CTRL, 32'h0000_0080);
        rdc(serial_pkg::IDX_CSR, 32'h0000_0000, "fault cleared");
        chk(irq, 1, "sticky irq");
        wr(serial_pkg::IDX_IRQ_EN, 32'h0000_0000);
        @(negedge pclk);
        chk(irq, 0, "masked");
        wr(serial_pkg::IDX_IRQ_EN, 32'h0000_0004);
        @(negedge pclk);
        chk(irq, 1, "unmasked");
        wr(serial_pkg::IDX_IRQ_CLR, 32'h0000_0004);
        @(negedge pclk);
        chk(irq, 0, "cleared");
    endtask : t_fault
    task automatic t_swsel();
        wr(serial_pkg::IDX_CSR, 32'h0000_0003);
        wr(serial_pkg::IDX_CTRL, 32'h0000_0050);
        pin_sel(1'b0);
        rdc(serial_pkg::IDX_CSR, 32'h0000_0003, "pin ignored");
        rdc(serial_pkg::IDX_CTRL, 32'h0000_0050, "still master");
        wr(serial_pkg::IDX_CSR, 32'h0000_0002);
        rdc(serial_pkg::IDX_CSR, 32'h0000_0012, "internal select");
        pin_sel(1'b1);
    endtask : t_swsel
    task automatic t_slave();
        wr(serial_pkg::IDX_CSR, 32'h0000_0000);
        wr(serial_pkg::IDX_CTRL, 32'h0000_0040);
        wr(serial_pkg::IDX_DATA, 32'h0000_0081);
        pin_sel(1'b0);
        chk(miso_oe, 1, "slave drives");
        send_slave(8'h5a);
        send_slave(8'hc3);
        rdc(serial_pkg::IDX_CSR, 32'h0000_00a0, "overrun");
        rdc(serial_pkg::IDX_DATA, 32'h0000_00c3, "slave rx");
        rdc(serial_pkg::IDX_CSR, 32'h0000_0000, "slave flags clear");
        pin_sel(1'b1);
        chk(miso_oe, 0, "slave released");
    endtask : t_slave
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        sel_n_in = 1'b1;
        ld = 1'b0;
        ftx = 8'h00;
        tb_sck = 1'b0;
        tb_mosi = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_xfer();
        t_inhibit();
        t_oe();
        t_fault();
        t_swsel();
        t_slave();
        end_of_test();
    end
endmodule : tb_top
